// ===== hdl/sccp_top.sv
// cycle-count register port: command decode and register file
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: host keeps serial clock at 1 MHz or less; the bench host runs it at 12.5 MHz
// R2: serial clock idles low, polarity zero only
// R3: first bit ready early, sample rising edges
// R4: host waits 1 us after select
// R5: same serial timing in both modes
// R6: idle automatically when not busy
// R7: start idle at power-up
// R8: standard protocol while mode input low
// R9: each axis count resets to 512
// R10: counts drive forward and reverse cycles
// R11: counts kept until rewritten or reset
// R12: host should program counts first; the bench host reads them once before its first write
// R13: command: bit7 one, bit6 direction, index low
// R14: direction one reads, zero writes
// R15: indices 3 to 8 map six registers
// R16: high byte at lower index, low next
// R17: pointer advances after each data byte
// R18: host writes command then high, low bytes
// R19: output released while select high
// R20: fresh select fall before each access
// R21: msb first, eight clocks per byte
// R22: reads return addressed register data
// R23: out-of-range writes are ignored
module sccp_top (
   input  wire logic   clk,              // system clock, 250 MHz
   input  wire logic   resetn,           // async reset, active low
   input  wire logic   sclk,             // serial clock from host
   input  wire logic   select_low_input, // select pin, low = selected
   input  wire logic   mosi,             // serial data in
   input  wire logic   mode_select,      // low = standard protocol
   output logic        miso,             // serial data out
   output logic        miso_oe,          // high while driving miso
   output logic        low_power_idle,   // high while idling
   output logic [15:0] x_cycle_count,    // x axis cycles per direction
   output logic [15:0] y_cycle_count,    // y axis cycles per direction
   output logic [15:0] z_cycle_count     // z axis cycles per direction
);
   sccp_link_if lnk ();

   // the shifter never sees the mode input, so timing is shared
   sccp_link u_link (                                            // R5
      .sclk             (sclk),
      .resetn           (resetn),
      .select_low_input (select_low_input),
      .mosi             (mosi),
      .miso             (miso),
      .lnk              (lnk.link)
   );

   // synchronisers; first stages feed only the second
   // select also resets the shifter directly; its release is safe only
   // because the host keeps the serial clock still around select edges
   logic                  sel_s1_reg, sel_s2_reg;
   logic                  mode_s1_reg, mode_s2_reg;
   logic                  tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sel_s1_reg  <= 1'b1;
         sel_s2_reg  <= 1'b1;
         mode_s1_reg <= 1'b0;
         mode_s2_reg <= 1'b0;
         tgl_s1_reg  <= 1'b0;
         tgl_s2_reg  <= 1'b0;
         tgl_s3_reg  <= 1'b0;
      end else begin
         sel_s1_reg  <= select_low_input;
         sel_s2_reg  <= sel_s1_reg;
         mode_s1_reg <= mode_select;
         mode_s2_reg <= mode_s1_reg;
         tgl_s1_reg  <= lnk.byte_tgl;
         tgl_s2_reg  <= tgl_s1_reg;
         tgl_s3_reg  <= tgl_s2_reg;
      end
   end

   wire logic             sel_act;
   wire logic             byte_evt;
   wire logic [7:0]       rx;

   assign sel_act  = ~sel_s2_reg;
   assign byte_evt = tgl_s2_reg ^ tgl_s3_reg;
   // rx_byte is held for a whole byte time after its toggle
   assign rx       = lnk.rx_byte;

   sccp_pkg::sccp_state_t state_reg, state_next;
   logic [3:0]            ptr_reg, ptr_next;
   logic                  rd_reg, rd_next;
   logic [7:0]            regs_reg [sccp_pkg::NUM_REGS];
   logic [7:0]            regs_next [sccp_pkg::NUM_REGS];
   logic [7:0]            tx_reg, tx_next;
   logic                  oe_reg, oe_next;
   logic                  idle_reg, idle_next;
   logic                  cmd_ok;
   logic                  ptr_valid;
   logic [3:0]            ptr_off;
   logic [2:0]            ptr_idx;

   always_comb begin
      cmd_ok = rx[sccp_pkg::CMD_ACCESS_BIT]                      // R13
               && !rx[sccp_pkg::CMD_ZERO_HI]
               && !rx[sccp_pkg::CMD_ZERO_LO]
               && !mode_s2_reg;                                  // R8
      ptr_valid = (ptr_reg >= sccp_pkg::IDX_X_HIGH)              // R15
                  && (ptr_reg <= sccp_pkg::IDX_Z_LOW);
      ptr_off = ptr_reg - sccp_pkg::IDX_X_HIGH;
      ptr_idx = ptr_off[2:0];
   end

   always_comb begin
      state_next = state_reg;
      ptr_next   = ptr_reg;
      rd_next    = rd_reg;
      regs_next  = regs_reg;
      if (!sel_act) begin
         // every access starts from a fresh select fall
         state_next = sccp_pkg::ST_IDLE;                         // R20
         rd_next    = 1'b0;
      end else begin
         case (state_reg)
            sccp_pkg::ST_IDLE: begin
               state_next = sccp_pkg::ST_CMD;
            end
            sccp_pkg::ST_CMD: begin
               if (byte_evt) begin
                  if (cmd_ok) begin
                     state_next = sccp_pkg::ST_DATA;
                     rd_next    = rx[sccp_pkg::CMD_READ_BIT];    // R14
                     ptr_next   = rx[sccp_pkg::CMD_IDX_HI:
                                     sccp_pkg::CMD_IDX_LO];
                  end else begin
                     state_next = sccp_pkg::ST_IGNORE;
                  end
               end
            end
            sccp_pkg::ST_DATA: begin
               if (byte_evt) begin
                  if (!rd_reg && ptr_valid) begin                // R23
                     regs_next[ptr_idx] = rx;                    // R14
                  end
                  ptr_next = ptr_reg + 4'h1;                     // R17
               end
            end
            sccp_pkg::ST_IGNORE: begin
               state_next = sccp_pkg::ST_IGNORE;
            end
            default: begin
               state_next = sccp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      // ready well before the falling edge that loads the next byte
      if (state_reg == sccp_pkg::ST_DATA && rd_reg && ptr_valid) begin
         tx_next = regs_reg[ptr_idx];                            // R22
      end else begin
         tx_next = 8'h00;
      end
      oe_next   = sel_act;                                       // R19
      // no measurement engine here, so only serial traffic wakes it
      idle_next = !sel_act;                                      // R6
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= sccp_pkg::ST_IDLE;                         // R7
         ptr_reg   <= 4'h0;
         rd_reg    <= 1'b0;
         tx_reg    <= 8'h00;
         oe_reg    <= 1'b0;
         idle_reg  <= 1'b1;                                      // R7
         for (int i = 0; i < sccp_pkg::NUM_REGS; i++) begin
            // even slots hold the high byte
            if (i % 2 == 0) begin                                // R16
               regs_reg[i] <= sccp_pkg::COUNT_RESET[15:8];       // R9
            end else begin
               regs_reg[i] <= sccp_pkg::COUNT_RESET[7:0];        // R9
            end
         end
      end else begin
         state_reg <= state_next;
         ptr_reg   <= ptr_next;
         rd_reg    <= rd_next;
         tx_reg    <= tx_next;
         oe_reg    <= oe_next;
         idle_reg  <= idle_next;
         regs_reg  <= regs_next;                                 // R11
      end
   end

   // tx_reg settles a few clk after the byte event and then stands until
   // the falling edge that loads it; slow serial clocks keep that order
   assign lnk.tx_byte    = tx_reg;
   assign miso_oe        = oe_reg;
   assign low_power_idle = idle_reg;
   assign x_cycle_count  = {regs_reg[0], regs_reg[1]};           // R10
   assign y_cycle_count  = {regs_reg[2], regs_reg[3]};           // R10
   assign z_cycle_count  = {regs_reg[4], regs_reg[5]};           // R10

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_oe_release: assert property (                               // R19
      $rose(select_low_input) |-> ##[1:4] !miso_oe)
      else $error("miso not released after deselect");

   a_idle_deselect: assert property (                            // R6
      !sel_act |-> ##1 low_power_idle && state_reg == sccp_pkg::ST_IDLE)
      else $error("not idle while deselected");

   a_bad_cmd_ignored: assert property (                          // R13
      byte_evt && state_reg == sccp_pkg::ST_CMD && sel_act
      && rx[7:4] != 4'h8 && rx[7:4] != 4'hc
      |=> state_reg == sccp_pkg::ST_IGNORE)
      else $error("malformed command accepted");

   a_legacy_blocked: assert property (                           // R8
      byte_evt && state_reg == sccp_pkg::ST_CMD && mode_s2_reg
      |=> state_reg != sccp_pkg::ST_DATA)
      else $error("access accepted in legacy mode");

   a_write_x_high: assert property (                             // R15
      byte_evt && sel_act && state_reg == sccp_pkg::ST_DATA && !rd_reg
      && ptr_reg == sccp_pkg::IDX_X_HIGH
      |=> x_cycle_count[15:8] == $past(rx))
      else $error("x high byte not written");

   a_ptr_advance: assert property (                              // R17
      byte_evt && sel_act && state_reg == sccp_pkg::ST_DATA
      |=> ptr_reg == $past(ptr_reg) + 4'h1)
      else $error("pointer did not advance");

   a_out_range_hold: assert property (                           // R23
      byte_evt && state_reg == sccp_pkg::ST_DATA && !ptr_valid
      |=> $stable(x_cycle_count) && $stable(y_cycle_count)
          && $stable(z_cycle_count))
      else $error("out-of-range write changed a count");

   a_read_low_x: assert property (                               // R22
      state_reg == sccp_pkg::ST_DATA && rd_reg
      && ptr_reg == sccp_pkg::IDX_X_LOW && sel_act
      |=> tx_reg == $past(x_cycle_count[7:0]))
      else $error("read byte does not match register");

   a_read_keeps: assert property (                               // R11
      state_reg == sccp_pkg::ST_DATA && rd_reg
      |=> $stable(x_cycle_count) && $stable(z_cycle_count))
      else $error("count changed during read");

   a_oe_select: assert property (                                // R19
      $fell(select_low_input) |-> ##[1:4] miso_oe)
      else $error("miso not driven after select");

   a_idle_wake: assert property (                                // R6
      $fell(select_low_input) |-> ##[1:4] !low_power_idle)
      else $error("still idle while selected");

   a_deselect_hold: assert property (                            // R11
      !sel_act |=> $stable(x_cycle_count) && $stable(y_cycle_count)
      && $stable(z_cycle_count))
      else $error("count changed while deselected");

   a_cmd_accept: assert property (                               // R14
      byte_evt && sel_act && state_reg == sccp_pkg::ST_CMD
      && !mode_s2_reg && (rx[7:4] == 4'h8 || rx[7:4] == 4'hc)
      |=> state_reg == sccp_pkg::ST_DATA && rd_reg == $past(rx[6]))
      else $error("valid command not decoded");

   a_cmd_pointer: assert property (                              // R13
      byte_evt && sel_act && state_reg == sccp_pkg::ST_CMD
      && !mode_s2_reg && rx[7] && rx[5:4] == 2'h0
      |=> ptr_reg == $past(rx[3:0]))
      else $error("command index not loaded");

   a_write_y_high: assert property (                             // R15
      byte_evt && sel_act && state_reg == sccp_pkg::ST_DATA && !rd_reg
      && ptr_reg == sccp_pkg::IDX_Y_HIGH
      |=> y_cycle_count[15:8] == $past(rx))
      else $error("y high byte not written");

   a_write_z_low: assert property (                              // R16
      byte_evt && sel_act && state_reg == sccp_pkg::ST_DATA && !rd_reg
      && ptr_reg == sccp_pkg::IDX_Z_LOW
      |=> z_cycle_count[7:0] == $past(rx))
      else $error("z low byte not written");

   a_read_no_write: assert property (                            // R14
      byte_evt && state_reg == sccp_pkg::ST_DATA && rd_reg
      |=> $stable(y_cycle_count))
      else $error("read changed a count");

   a_ignore_sticky: assert property (                            // R13
      state_reg == sccp_pkg::ST_IGNORE && sel_act |=> state_reg == sccp_pkg::ST_IGNORE)
      else $error("ignored frame resumed decoding");

   c_write_cmd: cover property (
      byte_evt && state_reg == sccp_pkg::ST_CMD && rx == 8'h83);
   c_burst_end: cover property (
      byte_evt && state_reg == sccp_pkg::ST_DATA && !rd_reg
      && ptr_reg == sccp_pkg::IDX_Z_LOW);
   c_read_data: cover property (
      state_reg == sccp_pkg::ST_DATA && rd_reg ##1 byte_evt);
   c_ignored: cover property (state_reg == sccp_pkg::ST_IGNORE);
   c_legacy_cmd: cover property (
      byte_evt && state_reg == sccp_pkg::ST_CMD && mode_s2_reg);

endmodule : sccp_top
`default_nettype wire

// ===== hdl/sccp_pkg.sv
// constants and types shared by the cycle-count serial port
package sccp_pkg;

   // command byte layout
   localparam int          CMD_ACCESS_BIT = 7;
   localparam int          CMD_READ_BIT   = 6;
   localparam int          CMD_ZERO_HI    = 5;
   localparam int          CMD_ZERO_LO    = 4;
   localparam int          CMD_IDX_HI     = 3;
   localparam int          CMD_IDX_LO     = 0;

   // register indices, high byte of each axis first
   localparam logic [3:0]  IDX_X_HIGH     = 4'h3;
   localparam logic [3:0]  IDX_X_LOW      = 4'h4;
   localparam logic [3:0]  IDX_Y_HIGH     = 4'h5;
   localparam logic [3:0]  IDX_Y_LOW      = 4'h6;
   localparam logic [3:0]  IDX_Z_HIGH     = 4'h7;
   localparam logic [3:0]  IDX_Z_LOW      = 4'h8;
   localparam int          NUM_REGS       = 6;

   // power-up cycle count, decimal 512
   localparam logic [15:0] COUNT_RESET    = 16'h0200;

   // serial framing
   localparam int          BYTE_BITS      = 8;
   localparam logic [2:0]  LAST_BIT       = 3'h7;
   localparam logic [2:0]  FIRST_BIT      = 3'h0;

   // timing figures
   localparam int          CLK_MHZ        = 250;
   localparam int          TRISTATE_NS    = 100;
   localparam int          TRISTATE_CYC   = TRISTATE_NS * CLK_MHZ / 1000;
   localparam int          SCLK_MAX_KHZ   = 1000;
   localparam int          SEL_TO_CMD_NS  = 1000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CMD,
      ST_DATA,
      ST_IGNORE
   } sccp_state_t;

endpackage : sccp_pkg

// ===== hdl/sccp_link_if.sv
// byte hand-over between the serial-clock side and the system-clock side
`timescale 1ns/1ps
`default_nettype none
interface sccp_link_if;
   logic [7:0] rx_byte;
   logic       byte_tgl;
   logic [7:0] tx_byte;

   modport link (output rx_byte, output byte_tgl, input tx_byte);
   modport core (input rx_byte, input byte_tgl, output tx_byte);
endinterface : sccp_link_if
`default_nettype wire

// ===== hdl/sccp_link.sv
// serial-clock shifter: mode 0, msb first, one toggle per byte
`timescale 1ns/1ps
`default_nettype none
module sccp_link (
   input  wire logic   sclk,             // serial clock from host
   input  wire logic   resetn,           // async reset, active low
   input  wire logic   select_low_input, // raw select pin, low = selected
   input  wire logic   mosi,             // serial data in
   output logic        miso,             // serial data out
   sccp_link_if.link   lnk               // byte hand-over
);
   wire logic       frame_rst_n;
   logic [2:0]      cnt_reg, cnt_next;
   logic [6:0]      shift_reg, shift_next;
   logic [7:0]      rx_reg, rx_next;
   logic            tgl_reg, tgl_next;
   logic [6:0]      txsh_reg, txsh_next;
   logic            miso_reg, miso_next;

   // the clock may stop outside frames, so the frame is ended by select
   assign frame_rst_n = resetn & ~select_low_input;

   always_comb begin
      cnt_next   = cnt_reg + 3'h1;
      shift_next = {shift_reg[5:0], mosi};                       // R21
      rx_next    = rx_reg;
      tgl_next   = tgl_reg;
      if (cnt_reg == sccp_pkg::LAST_BIT) begin
         rx_next  = {shift_reg, mosi};
         tgl_next = ~tgl_reg;
      end
   end

   // sample on rising edges only
   always_ff @(posedge sclk or negedge frame_rst_n) begin        // R3
      if (!frame_rst_n) begin
         cnt_reg   <= 3'h0;                                      // R2
         shift_reg <= 7'h00;
      end else begin
         cnt_reg   <= cnt_next;
         shift_reg <= shift_next;
      end
   end

   // kept across frames so a frame end never fakes a byte event
   always_ff @(posedge sclk or negedge resetn) begin
      if (!resetn) begin
         rx_reg  <= 8'h00;
         tgl_reg <= 1'b0;
      end else begin
         rx_reg  <= rx_next;
         tgl_reg <= tgl_next;
      end
   end

   always_comb begin
      if (cnt_reg == sccp_pkg::FIRST_BIT) begin
         miso_next = lnk.tx_byte[7];                             // R22
         txsh_next = lnk.tx_byte[6:0];
      end else begin
         miso_next = txsh_reg[6];                                // R21
         txsh_next = {txsh_reg[5:0], 1'b0};
      end
   end

   // output changes on falling edges; the next msb sits ready before
   // the first rising edge of each byte after the command byte
   always_ff @(negedge sclk or negedge frame_rst_n) begin        // R3
      if (!frame_rst_n) begin
         miso_reg <= 1'b0;
         txsh_reg <= 7'h00;
      end else begin
         miso_reg <= miso_next;
         txsh_reg <= txsh_next;
      end
   end

   assign miso         = miso_reg;
   assign lnk.rx_byte  = rx_reg;
   assign lnk.byte_tgl = tgl_reg;

   a_byte_toggle: assert property (                              // R21
      @(posedge sclk) disable iff (!frame_rst_n)
      cnt_reg == sccp_pkg::LAST_BIT |=> tgl_reg != $past(tgl_reg))
      else $error("byte toggle missing after eighth bit");

   a_rx_capture: assert property (                               // R3
      @(posedge sclk) disable iff (!frame_rst_n)
      cnt_reg == sccp_pkg::LAST_BIT |=> rx_reg[0] == $past(mosi))
      else $error("last bit of byte not captured");

endmodule : sccp_link
`default_nettype wire

// ===== verification/sccp_host.sv
// host serial master model for the cycle-count port
`timescale 1ns/1ps
`default_nettype none
module sccp_host (
   output logic      sclk,             // serial clock, still between frames
   output logic      select_low_input, // select, low = selected
   output logic      mosi,             // serial data to device
   input  wire logic miso              // serial data from device
);
   // 80 ns period runs the clock at 12.5 MHz, above the 1 MHz ceiling
   localparam int HALF_NS = 40;

   initial begin
      sclk             = 1'b0;
      select_low_input = 1'b1;
      mosi             = 1'b0;
   end

   task automatic open_frame();
      select_low_input = 1'b0;
      #1000;
   endtask : open_frame

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         #(HALF_NS);
         sclk  = 1'b1;
         rx[i] = miso;
         #(HALF_NS);
         sclk = 1'b0;
      end
   endtask : xfer

   task automatic close_frame();
      #(HALF_NS);
      select_low_input = 1'b1;
      // a released line must not keep showing the last bit
      mosi = ~mosi;
      #(HALF_NS);
   endtask : close_frame
endmodule : sccp_host
`default_nettype wire

// ===== verification/sccp_top_test.sv
// self-checking bench for the cycle-count port
`timescale 1ns/1ps
`default_nettype none
module sccp_top_test;
   localparam int TIMEOUT_CYC = 60000;
   logic        clk;
   logic        resetn;
   logic        mode_select;
   logic        sclk;
   logic        select_low_input;
   logic        mosi;
   logic        miso;
   logic        miso_line;
   logic        miso_oe;
   logic        low_power_idle;
   logic [15:0] x_cycle_count;
   logic [15:0] y_cycle_count;
   logic [15:0] z_cycle_count;
   int          err_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   logic [7:0]  mdl [16];

   sccp_top sccp_top_inst (
      .clk(clk), .resetn(resetn), .sclk(sclk),
      .select_low_input(select_low_input), .mosi(mosi),
      .mode_select(mode_select), .miso(miso), .miso_oe(miso_oe),
      .low_power_idle(low_power_idle), .x_cycle_count(x_cycle_count),
      .y_cycle_count(y_cycle_count), .z_cycle_count(z_cycle_count)
   );

   sccp_host sccp_host_inst (
      .sclk(sclk), .select_low_input(select_low_input),
      .mosi(mosi), .miso(miso_line)
   );

   // a released line shows the inverse, so a late enable is caught
   assign miso_line = miso_oe ? miso : ~miso;

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == TIMEOUT_CYC) begin
         err_count++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (err_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic report(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : report

   task automatic chk_count(input logic [15:0] got, input logic [15:0] exp);
      report(got, exp);
   endtask : chk_count

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      report({8'h00, got}, {8'h00, exp});
   endtask : chk_byte

   task automatic chk_flag(input logic got, input logic exp);
      report({15'h0000, got}, {15'h0000, exp});
   endtask : chk_flag

   task automatic chk_counts();
      chk_count(x_cycle_count, {mdl[3], mdl[4]});
      chk_count(y_cycle_count, {mdl[5], mdl[6]});
      chk_count(z_cycle_count, {mdl[7], mdl[8]});
   endtask : chk_counts

   task automatic reset_dut();
      @(posedge clk) #1 resetn <= 1'b0;
      repeat (2) @(posedge clk);
      #1 resetn <= 1'b1;
      for (int i = 0; i < 16; i++) mdl[i] = 8'h00;
      mdl[3] = 8'h02;
      mdl[5] = 8'h02;
      mdl[7] = 8'h02;
      repeat (4) @(posedge clk);
      #1;
   endtask : reset_dut

   task automatic set_mode(input logic m);
      @(posedge clk) #1 mode_select <= m;
      repeat (4) @(posedge clk);
   endtask : set_mode

   // one framed access: command byte, then n random data bytes
   task automatic access(input logic [7:0] cmd, input int n);
      logic [7:0] rx;
      logic [7:0] d;
      logic [7:0] exp;
      logic [3:0] ptr;
      logic       ok;
      logic       hit;
      ok  = cmd[7] && cmd[5:4] == 2'h0 && !mode_select;
      ptr = cmd[3:0];
      // keep host edges clear of the system clock edges
      @(posedge clk);
      #1;
      sccp_host_inst.open_frame();
      chk_flag(miso_oe, 1'b1);
      chk_flag(low_power_idle, 1'b0);
      sccp_host_inst.xfer(cmd, rx);
      chk_byte(rx, 8'h00);
      for (int i = 0; i < n; i++) begin
         d   = 8'($urandom);
         hit = ok && ptr >= 4'h3 && ptr <= 4'h8;
         exp = (hit && cmd[6]) ? mdl[ptr] : 8'h00;
         sccp_host_inst.xfer(d, rx);
         chk_byte(rx, exp);
         if (hit && !cmd[6]) mdl[ptr] = d;
         ptr = ptr + 4'h1;
      end
      sccp_host_inst.close_frame();
      repeat (6) @(posedge clk);
      #1;
      chk_flag(miso_oe, 1'b0);
      chk_flag(low_power_idle, 1'b1);
      chk_counts();
   endtask : access

   initial begin
      resetn      = 1'b0;
      mode_select = 1'b0;
      void'($urandom(32'hdfc1379e));
      reset_dut();
      chk_counts();
      chk_flag(low_power_idle, 1'b1);
      chk_flag(miso_oe, 1'b0);
      access(8'hc3, 6);
      access(8'h83, 6);
      access(8'hc3, 6);
      for (int i = 3; i <= 8; i++) begin
         access(8'h80 | 8'(i), 1);
         access(8'hc0 | 8'(i), 1);
      end
      access(8'h85, 1);
      access(8'hc0, 4);
      access(8'h88, 2);
      access(8'h89, 2);
      access(8'h8f, 5);
      access(8'h03, 2);
      access(8'hb3, 2);
      set_mode(1'b1);
      access(8'h83, 2);
      set_mode(1'b0);
      access(8'hc3, 6);
      reset_dut();
      chk_counts();
      complete_run();
   end
endmodule : sccp_top_test
`default_nettype wire
